// file: cbe_pkg.sv
`default_nettype none
package cbe_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int PC_W = 16;
   localparam int OP_W = 16;
   localparam int OFS_W = 8;
   localparam int FLAG_W = 8;
   localparam int CNT_W = 16;
   localparam int SEL_W = 4;

   // ---------------------------------------------------------------
   // opcode layout: class field, condition select, signed offset
   // ---------------------------------------------------------------
   localparam int OP_CLASS_HI = 15;
   localparam int OP_CLASS_LO = 12;
   localparam int OP_SEL_HI = 11;
   localparam int OP_SEL_LO = 8;
   localparam int OP_OFS_HI = 7;
   localparam int OP_OFS_LO = 0;
   localparam logic [3:0] OP_CLASS_BRANCH = 4'hF;

   // condition select codes
   localparam logic [SEL_W-1:0] SEL_CARRY_CLEAR = 4'h0;
   localparam logic [SEL_W-1:0] SEL_SAME_OR_HIGHER = 4'h1;
   localparam logic [SEL_W-1:0] SEL_LOWER_UNSIGNED = 4'h2;
   localparam logic [SEL_W-1:0] SEL_NEGATIVE = 4'h3;
   localparam logic [SEL_W-1:0] SEL_NONNEGATIVE = 4'h4;
   localparam logic [SEL_W-1:0] SEL_SIGNED_GE = 4'h5;
   localparam logic [SEL_W-1:0] SEL_SIGNED_LESS = 4'h6;
   localparam logic [SEL_W-1:0] SEL_HALF_CARRY_SET = 4'h7;
   localparam logic [SEL_W-1:0] SEL_HALF_CARRY_CLEAR = 4'h8;
   localparam logic [SEL_W-1:0] SEL_TRANSFER_BIT_SET = 4'h9;

   // ---------------------------------------------------------------
   // status flag positions
   // ---------------------------------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;

   // ---------------------------------------------------------------
   // register map (byte addresses) and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TAKEN_CNT = 8'h08;
   localparam logic [7:0] ADDR_SKIP_CNT = 8'h0C;
   localparam logic [7:0] ADDR_LAST_PC = 8'h10;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_TAKEN_BIT = 1;
   localparam int STAT_ILLEGAL_BIT = 2;
   localparam int STAT_SEL_LO = 4;

   // ---------------------------------------------------------------
   // cycle cost
   // ---------------------------------------------------------------
   localparam int CYC_NOT_TAKEN = 1;
   localparam int CYC_TAKEN = 2;

   // one-hot sequencer states
   typedef enum logic [1:0] {
      CBE_IDLE = 2'b01,
      CBE_TAKE = 2'b10
   } cbe_state_t;
endpackage : cbe_pkg
`default_nettype wire

// file: cbe_br_if.sv
`default_nettype none
interface cbe_br_if;
   logic [cbe_pkg::SEL_W-1:0] sel;
   logic [cbe_pkg::FLAG_W-1:0] flags;
   logic [cbe_pkg::PC_W-1:0] pc;
   logic [cbe_pkg::OFS_W-1:0] offset;
   logic cond_true;
   logic sel_legal;
   logic [cbe_pkg::PC_W-1:0] target;
   logic [cbe_pkg::PC_W-1:0] seq_pc;

   modport ctl (output sel, flags, pc, offset, input cond_true, sel_legal, target, seq_pc);
   modport eval (input sel, flags, output cond_true, sel_legal);
   modport adder (input pc, offset, output target, seq_pc);
endinterface : cbe_br_if
`default_nettype wire

// file: cbe_cond_eval.sv
`default_nettype none
module cbe_cond_eval (
   cbe_br_if.eval br
);
   logic c;
   logic n;
   logic v;
   logic h;
   logic t;

   // flags are only read here, never written back
   assign c = br.flags[cbe_pkg::FLAG_C];
   assign n = br.flags[cbe_pkg::FLAG_N];
   assign v = br.flags[cbe_pkg::FLAG_V];
   assign h = br.flags[cbe_pkg::FLAG_H];
   assign t = br.flags[cbe_pkg::FLAG_T];

   // condition per select code; unused codes are flagged illegal
   always_comb begin
      br.cond_true = 1'b0;
      br.sel_legal = 1'b1;
      unique case (br.sel)
         cbe_pkg::SEL_CARRY_CLEAR: br.cond_true = ~c;
         cbe_pkg::SEL_SAME_OR_HIGHER: br.cond_true = ~c;
         cbe_pkg::SEL_LOWER_UNSIGNED: br.cond_true = c;
         cbe_pkg::SEL_NEGATIVE: br.cond_true = n;
         cbe_pkg::SEL_NONNEGATIVE: br.cond_true = ~n;
         cbe_pkg::SEL_SIGNED_GE: br.cond_true = ~(n ^ v);
         cbe_pkg::SEL_SIGNED_LESS: br.cond_true = n ^ v;
         cbe_pkg::SEL_HALF_CARRY_SET: br.cond_true = h;
         cbe_pkg::SEL_HALF_CARRY_CLEAR: br.cond_true = ~h;
         cbe_pkg::SEL_TRANSFER_BIT_SET: br.cond_true = t;
         default: begin
            br.cond_true = 1'b0;
            br.sel_legal = 1'b0;
         end
      endcase
   end
endmodule : cbe_cond_eval
`default_nettype wire

// file: cbe_target_add.sv
`default_nettype none
module cbe_target_add (
   cbe_br_if.adder br
);
   logic [cbe_pkg::PC_W-1:0] ofs_ext;
   localparam logic [cbe_pkg::PC_W-1:0] ONE = 16'h0001;

   // sign-extend the word displacement to pc width
   assign ofs_ext = {{(cbe_pkg::PC_W-cbe_pkg::OFS_W){br.offset[cbe_pkg::OFS_W-1]}},
                     br.offset};
   // wraps modulo pc width, like the program counter itself
   assign br.target = br.pc + ofs_ext + ONE;
   assign br.seq_pc = br.pc + ONE;
endmodule : cbe_target_add
`default_nettype wire

// file: cbe_branch_unit.sv
// Summary of operation
// - carry-clear branch is taken only when carry is 0, else falls through.
// - same-or-higher branch is taken when carry is 0, same as carry-clear.
// - unsigned lower branch is taken only when carry is 1.
// - negative branch is taken only when the negative flag is 1.
// - nonnegative branch is taken only when the negative flag is 0.
// - signed greater-or-equal is taken when negative xor overflow is 0.
// - signed less-than is taken when negative xor overflow is 1.
// - half-carry-set branch is taken only when half-carry is 1.
// - half-carry-clear branch is taken only when half-carry is 0.
// - transfer-bit-set branch is taken only when the transfer bit is 1.
// - a taken branch loads pc plus offset plus one.
// - no status flag changes, taken or not.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`default_nettype none
module cbe_branch_unit #(
   parameter int PC_W = cbe_pkg::PC_W,
   parameter int CNT_W = cbe_pkg::CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // fetch stage side
   input wire logic instr_valid,
   input wire logic [cbe_pkg::OP_W-1:0] instr_op,
   input wire logic [PC_W-1:0] instr_pc,
   input wire logic [cbe_pkg::FLAG_W-1:0] status_flags,
   output logic instr_ready,
   // program counter steering
   output logic done,
   output logic taken,
   output logic pc_load,
   output logic [PC_W-1:0] pc_value,
   output logic flags_write
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   cbe_br_if br ();

   cbe_cond_eval u_eval (
      .br (br)
   );

   cbe_target_add u_add (
      .br (br)
   );

   logic is_branch;
   logic accept;
   logic ctrl_en_reg;
   logic ctrl_en_next;
   logic busy_reg;
   logic busy_next;

   // the class field picks out the branches this unit owns
   assign is_branch = instr_op[cbe_pkg::OP_CLASS_HI:cbe_pkg::OP_CLASS_LO]
                      == cbe_pkg::OP_CLASS_BRANCH;
   assign br.sel = instr_op[cbe_pkg::OP_SEL_HI:cbe_pkg::OP_SEL_LO];
   assign br.offset = instr_op[cbe_pkg::OP_OFS_HI:cbe_pkg::OP_OFS_LO];
   assign br.pc = instr_pc;
   assign br.flags = status_flags;
   // new opcodes are only looked at while idle and enabled
   assign accept = instr_valid & ~busy_reg & ctrl_en_reg & is_branch & br.sel_legal;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   cbe_pkg::cbe_state_t state_reg;
   cbe_pkg::cbe_state_t state_next;
   logic done_reg;
   logic done_next;
   logic taken_reg;
   logic taken_next;
   logic pc_load_reg;
   logic pc_load_next;
   logic [PC_W-1:0] pc_value_reg;
   logic [PC_W-1:0] pc_value_next;
   logic [PC_W-1:0] target_hold_reg;
   logic [PC_W-1:0] target_hold_next;

   // taken branches hold one extra cycle so fetch can refill from the target
   always_comb begin
      state_next = state_reg;
      done_next = 1'b0;
      taken_next = taken_reg;
      pc_load_next = 1'b0;
      pc_value_next = pc_value_reg;
      target_hold_next = target_hold_reg;
      busy_next = busy_reg;
      unique case (state_reg)
         cbe_pkg::CBE_IDLE: begin
            if (accept && br.cond_true) begin
               state_next = cbe_pkg::CBE_TAKE;
               target_hold_next = br.target;
               busy_next = 1'b1;
               taken_next = 1'b1;
            end else if (accept) begin
               done_next = 1'b1;
               taken_next = 1'b0;
               pc_value_next = br.seq_pc;
            end
         end
         cbe_pkg::CBE_TAKE: begin
            state_next = cbe_pkg::CBE_IDLE;
            done_next = 1'b1;
            pc_load_next = 1'b1;
            pc_value_next = target_hold_reg;
            busy_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= cbe_pkg::CBE_IDLE;
         done_reg <= 1'b0;
         taken_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         pc_value_reg <= '0;
         target_hold_reg <= '0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         done_reg <= done_next;
         taken_reg <= taken_next;
         pc_load_reg <= pc_load_next;
         pc_value_reg <= pc_value_next;
         target_hold_reg <= target_hold_next;
         busy_reg <= busy_next;
      end
   end

   // ---------------------------------------------------------------
   // fetch handshake and flag write enable
   // ---------------------------------------------------------------
   logic ready_reg;
   logic ready_next;
   logic flags_write_reg;
   logic flags_write_next;

   // ready drops in the cycle after a taken branch is accepted, so it is registered
   always_comb begin
      ready_next = ~busy_next;
      // this unit never asks for a status write-back
      flags_write_next = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_reg <= 1'b1;
         flags_write_reg <= 1'b0;
      end else begin
         ready_reg <= ready_next;
         flags_write_reg <= flags_write_next;
      end
   end

   // ---------------------------------------------------------------
   // statistics and last-branch status
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] taken_cnt_reg;
   logic [CNT_W-1:0] taken_cnt_next;
   logic [CNT_W-1:0] skip_cnt_reg;
   logic [CNT_W-1:0] skip_cnt_next;
   logic [cbe_pkg::SEL_W-1:0] last_sel_reg;
   logic [cbe_pkg::SEL_W-1:0] last_sel_next;
   logic illegal_reg;
   logic illegal_next;
   logic [PC_W-1:0] last_pc_reg;
   logic [PC_W-1:0] last_pc_next;
   logic clr_pulse;
   logic take_evt;
   logic skip_evt;
   logic bad_evt;

   assign take_evt = accept & br.cond_true;
   assign skip_evt = accept & ~br.cond_true;
   assign bad_evt = instr_valid & ~busy_reg & ctrl_en_reg & is_branch & ~br.sel_legal;

   // an event in the clearing cycle still counts, so the set wins
   always_comb begin
      taken_cnt_next = clr_pulse ? '0 : taken_cnt_reg;
      skip_cnt_next = clr_pulse ? '0 : skip_cnt_reg;
      illegal_next = clr_pulse ? 1'b0 : illegal_reg;
      last_sel_next = last_sel_reg;
      last_pc_next = last_pc_reg;
      if (take_evt) begin
         taken_cnt_next = taken_cnt_next + 1'b1;
      end
      if (skip_evt) begin
         skip_cnt_next = skip_cnt_next + 1'b1;
      end
      if (bad_evt) begin
         illegal_next = 1'b1;
      end
      if (accept) begin
         last_sel_next = br.sel;
         last_pc_next = instr_pc;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         taken_cnt_reg <= '0;
         skip_cnt_reg <= '0;
         illegal_reg <= 1'b0;
         last_sel_reg <= '0;
         last_pc_reg <= '0;
      end else begin
         taken_cnt_reg <= taken_cnt_next;
         skip_cnt_reg <= skip_cnt_next;
         illegal_reg <= illegal_next;
         last_sel_reg <= last_sel_next;
         last_pc_reg <= last_pc_next;
      end
   end

   // ---------------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------------
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic apb_done;
   logic apb_wr;
   logic mapped;
   logic [31:0] rd_mux;

   // pready rises in the first access cycle: one setup, one access, no waits
   assign apb_done = psel & penable & pready_reg;
   assign apb_wr = apb_done & pwrite & ~pslverr_reg;
   assign clr_pulse = apb_wr & (paddr == cbe_pkg::ADDR_CTRL) & pwdata[cbe_pkg::CTRL_CLR_BIT];

   // read data is decoded in the setup cycle and held for the access cycle
   always_comb begin
      rd_mux = 32'h0000_0000;
      mapped = 1'b1;
      unique case (paddr)
         cbe_pkg::ADDR_CTRL: rd_mux[cbe_pkg::CTRL_EN_BIT] = ctrl_en_reg;
         cbe_pkg::ADDR_STATUS: begin
            rd_mux[cbe_pkg::STAT_BUSY_BIT] = busy_reg;
            rd_mux[cbe_pkg::STAT_TAKEN_BIT] = taken_reg;
            rd_mux[cbe_pkg::STAT_ILLEGAL_BIT] = illegal_reg;
            rd_mux[cbe_pkg::STAT_SEL_LO +: cbe_pkg::SEL_W] = last_sel_reg;
         end
         cbe_pkg::ADDR_TAKEN_CNT: rd_mux[CNT_W-1:0] = taken_cnt_reg;
         cbe_pkg::ADDR_SKIP_CNT: rd_mux[CNT_W-1:0] = skip_cnt_reg;
         cbe_pkg::ADDR_LAST_PC: rd_mux[PC_W-1:0] = last_pc_reg;
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      pready_next = psel & ~penable;
      pslverr_next = psel & ~penable & ~mapped;
      prdata_next = prdata_reg;
      ctrl_en_next = ctrl_en_reg;
      if (psel && !penable) begin
         prdata_next = (pwrite || !mapped) ? 32'h0000_0000 : rd_mux;
      end
      if (apb_wr && paddr == cbe_pkg::ADDR_CTRL) begin
         ctrl_en_next = pwdata[cbe_pkg::CTRL_EN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         ctrl_en_reg <= cbe_pkg::CTRL_EN_RST;
      end else begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         ctrl_en_reg <= ctrl_en_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign instr_ready = ready_reg;
   assign done = done_reg;
   assign taken = taken_reg;
   assign pc_load = pc_load_reg;
   assign pc_value = pc_value_reg;
   assign flags_write = flags_write_reg;
endmodule : cbe_branch_unit
`default_nettype wire

// file: cbe_ref.svh
`ifndef CBE_REF_SVH
`define CBE_REF_SVH
// expected branch outcome from the select field and the sampled status flags
function automatic logic cbe_cond(input logic [15:0] op, input logic [7:0] f);
   case (op[11:8])
      4'h0, 4'h1: cbe_cond = !f[cbe_pkg::FLAG_C];
      4'h2: cbe_cond = f[cbe_pkg::FLAG_C];
      4'h3: cbe_cond = f[cbe_pkg::FLAG_N];
      4'h4: cbe_cond = !f[cbe_pkg::FLAG_N];
      4'h5: cbe_cond = !(f[cbe_pkg::FLAG_N] ^ f[cbe_pkg::FLAG_V]);
      4'h6: cbe_cond = f[cbe_pkg::FLAG_N] ^ f[cbe_pkg::FLAG_V];
      4'h7: cbe_cond = f[cbe_pkg::FLAG_H];
      4'h8: cbe_cond = !f[cbe_pkg::FLAG_H];
      4'h9: cbe_cond = f[cbe_pkg::FLAG_T];
      default: cbe_cond = 1'b0;
   endcase
endfunction : cbe_cond
// offset widened with its sign, sum wraps at 16 bits
function automatic logic [15:0] cbe_tgt(input logic [15:0] pc, input logic [15:0] op);
   cbe_tgt = pc + {{8{op[7]}}, op[7:0]} + 16'h0001;
endfunction : cbe_tgt
`endif

// file: cbe_branch_unit_monitor.sv
`default_nettype none
`include "cbe_ref.svh"
module cbe_branch_unit_monitor #(
   parameter int PC_W = cbe_pkg::PC_W,
   parameter int CNT_W = cbe_pkg::CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic instr_valid,
   input wire logic [cbe_pkg::OP_W-1:0] instr_op,
   input wire logic [PC_W-1:0] instr_pc,
   input wire logic [cbe_pkg::FLAG_W-1:0] status_flags,
   input wire logic instr_ready,
   input wire logic done,
   input wire logic taken,
   input wire logic pc_load,
   input wire logic [PC_W-1:0] pc_value,
   input wire logic flags_write
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a completion is traced back to the accept edge one or two cycles earlier
   chk_flags_quiet: assert property (!flags_write)
      else $error("flag write from a branch");
   chk_skip_cond: assert property (done && !taken |-> !cbe_cond($past(instr_op),
      $past(status_flags))) else $error("branch skipped with condition true");
   chk_skip_pc: assert property (done && !taken |->
      pc_value == $past(instr_pc) + 16'h0001) else $error("skipped branch pc wrong");
   chk_take_cond: assert property (done && taken |-> cbe_cond($past(instr_op, 2),
      $past(status_flags, 2))) else $error("branch taken with condition false");
   chk_take_pc: assert property (done && taken |->
      pc_value == cbe_tgt($past(instr_pc, 2), $past(instr_op, 2))) else $error("target wrong");
   chk_take_stall: assert property (done && taken |-> $past(instr_ready) == 1'b0)
      else $error("taken branch finished in one cycle");
   chk_load_pair: assert property (pc_load |-> done && taken)
      else $error("pc load outside a taken completion");
   chk_ready_back: assert property (!instr_ready |=> instr_ready && done && pc_load)
      else $error("stall cycle not followed by load");
endmodule : cbe_branch_unit_monitor
bind cbe_branch_unit cbe_branch_unit_monitor #(.PC_W(PC_W), .CNT_W(CNT_W)) mon_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .instr_valid(instr_valid), .instr_op(instr_op), .instr_pc(instr_pc),
   .status_flags(status_flags), .instr_ready(instr_ready), .done(done), .taken(taken),
   .pc_load(pc_load), .pc_value(pc_value), .flags_write(flags_write)
);
`default_nettype wire

// file: cbe_fetch_model.sv
`default_nettype none
module cbe_fetch_model (
   input wire logic pclk,
   input wire logic instr_ready,
   output logic instr_valid,
   output logic [15:0] instr_op,
   output logic [15:0] instr_pc,
   output logic [7:0] status_flags,
   output logic stuck
);
   timeunit 1ns;
   timeprecision 1ns;
   // quiet lines at time zero
   initial begin
      instr_valid = 1'b0;
      instr_op = 16'h0000;
      instr_pc = 16'h0000;
      status_flags = 8'h00;
      stuck = 1'b0;
   end
   // call just after an edge; holds the offer until the edge that takes it
   task automatic offer(input logic [15:0] op, input logic [15:0] pc, input logic [7:0] f);
      int n;
      instr_valid <= 1'b1;
      instr_op <= op;
      instr_pc <= pc;
      status_flags <= f;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (instr_ready === 1'b1) break;
      end
      // set at once so the caller sees it in this same time step
      if (n == 20) stuck = 1'b1;
   endtask : offer
   // stale opcode and flags are inverted so a late sample cannot look right
   task automatic idle();
      instr_valid <= 1'b0;
      instr_op <= ~instr_op;
      instr_pc <= ~instr_pc;
      status_flags <= ~status_flags;
      @(posedge pclk);
   endtask : idle
endmodule : cbe_fetch_model
`default_nettype wire

// file: cbe_branch_unit_test.sv
`default_nettype none
// shared reference functions live in the compilation unit, so the guard cannot hide them
`include "cbe_ref.svh"
module cbe_branch_unit_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, e_t;
   logic [7:0] paddr, status_flags;
   logic [31:0] pwdata, prdata, rd;
   logic instr_valid, instr_ready, done, taken, pc_load, flags_write, stuck;
   logic [15:0] instr_op, instr_pc, pc_value, e_p;
   logic [15:0] exp_pc[$];
   logic exp_tk[$];
   logic [7:0] fl[8] = '{8'h00, 8'hFF, 8'h01, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h40};
   int n_mismatch = 0, comparisons = 0, n_tk = 0, n_sk = 0;
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   cbe_branch_unit dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_valid(instr_valid), .instr_op(instr_op), .instr_pc(instr_pc),
      .status_flags(status_flags), .instr_ready(instr_ready), .done(done), .taken(taken),
      .pc_load(pc_load), .pc_value(pc_value), .flags_write(flags_write)
   );
   cbe_fetch_model fm (
      .pclk(pclk), .instr_ready(instr_ready), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_pc(instr_pc), .status_flags(status_flags), .stuck(stuck)
   );
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   // one apb transfer, no wait-state count assumed
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         n_mismatch++;
         summarize();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic xe);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
      check(32'(er), 32'(xe));
   endtask : rchk
   task automatic put(input logic [15:0] op, input logic [15:0] pc, input logic [7:0] f);
      fm.offer(op, pc, f);
      if (stuck === 1'b1) begin
         n_mismatch++;
         summarize();
      end
   endtask : put
   // legal branch with its predicted outcome queued first
   task automatic br(input logic [3:0] s, input logic [7:0] k, input logic [15:0] pc,
                     input logic [7:0] f);
      logic [15:0] op;
      op = {cbe_pkg::OP_CLASS_BRANCH, s, k};
      exp_tk.push_back(cbe_cond(op, f));
      exp_pc.push_back(cbe_cond(op, f) ? cbe_tgt(pc, op) : pc + 16'h0001);
      if (cbe_cond(op, f)) n_tk++;
      else n_sk++;
      put(op, pc, f);
   endtask : br
   // idle, then allow the two-cycle answer time for anything still due
   task automatic drain();
      fm.idle();
      for (int n = 0; n < 20 && exp_tk.size() > 0; n++) @(posedge pclk);
      repeat (2) @(posedge pclk);
      check(32'(exp_tk.size()), 32'h0);
   endtask : drain
   // each completion is matched against the oldest prediction
   always @(posedge pclk) begin
      if (done === 1'b1) begin
         if (exp_tk.size() == 0) begin
            check(32'(done), 32'h0);
         end else begin
            e_t = exp_tk.pop_front();
            e_p = exp_pc.pop_front();
            check(32'(taken), 32'(e_t));
            check(32'(pc_load), 32'(e_t));
            check(32'(pc_value), 32'(e_p));
            check(32'(flags_write), 32'h0);
         end
      end
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      summarize();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 5; i++) rchk(8'(4 * i), 32'(i == 0), 1'b0);
      rchk(8'h14, 32'h0, 1'b1);
      apb(1'b1, cbe_pkg::ADDR_STATUS, 32'hFF);
      rchk(cbe_pkg::ADDR_STATUS, 32'h0, 1'b0);
      // every select against every flag pattern, back to back, across pc wrap
      for (int s = 0; s < 10; s++) begin
         for (int j = 0; j < 8; j++) br(4'(s), 8'(8'h7C + j), 16'(16'hFFFA + j), fl[j]);
      end
      drain();
      rchk(cbe_pkg::ADDR_TAKEN_CNT, 32'(n_tk), 1'b0);
      rchk(cbe_pkg::ADDR_SKIP_CNT, 32'(n_sk), 1'b0);
      rchk(cbe_pkg::ADDR_LAST_PC, 32'h1, 1'b0);
      rchk(cbe_pkg::ADDR_STATUS, 32'h92, 1'b0);
      put(16'hFA00, 16'h0100, 8'h00);
      put(16'h1234, 16'h0101, 8'h00);
      drain();
      rchk(cbe_pkg::ADDR_STATUS, 32'h96, 1'b0);
      apb(1'b1, cbe_pkg::ADDR_CTRL, 32'h3);
      rchk(cbe_pkg::ADDR_TAKEN_CNT, 32'h0, 1'b0);
      rchk(cbe_pkg::ADDR_STATUS, 32'h92, 1'b0);
      apb(1'b1, cbe_pkg::ADDR_CTRL, 32'h0);
      put(16'hF005, 16'h0200, 8'h00);
      drain();
      rchk(cbe_pkg::ADDR_CTRL, 32'h0, 1'b0);
      apb(1'b1, cbe_pkg::ADDR_CTRL, 32'h1);
      br(4'h0, 8'h80, 16'h0000, 8'h00);
      drain();
      summarize();
   end
endmodule : cbe_branch_unit_test
`default_nettype wire
